// file: common/mr0_map.svh
// Offsets, field positions, encodings and timing counts of the mode register zero link.
`ifndef MR0_MAP_SVH
`define MR0_MAP_SVH
`define MRSEL_MR0 3'h0
`define MRSEL_MR1 3'h1
`define MRSEL_MR2 3'h2
`define MRSEL_MR5 3'h5
`define MRSEL_RCW 3'h7
`define BIT_BL 0
`define BIT_CL_LO 2
`define BIT_BT 3
`define BIT_CL_HI 4
`define BIT_TM 7
`define BIT_DLLRST 8
`define BIT_WR 9
`define BIT_AL 3
`define BIT_CRC 12
`define BIT_DM 10
`define BIT_BC 12
`define BIT_UNUSED 17
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
`define AL_CLM1 2'h1
`define AL_CLM2 2'h2
`define CL_BASE 5'h09
`define BURST_SLOT 4'h8
`define WR_PULL_IN 4'h2
`define WR_DONE 4'h9
`define LOCK_WAIT_CYCLES 1024
`define REG_CMD 5'h00
`define REG_WDATA0 5'h04
`define REG_WDATA1 5'h08
`define REG_MASK 5'h0c
`define REG_STATUS 5'h10
`define REG_RDATA0 5'h14
`define REG_RDATA1 5'h18
`define CMD_SEL 18
`define CMD_KIND 21
`define CMD_BADCRC 23
`endif

// file: common/mr0_pkg.sv
// Types and shared functions of the mode register zero link.
`include "mr0_map.svh"
package mr0_pkg;
  typedef enum logic [1:0] {CMD_NOP, CMD_MRS, CMD_READ, CMD_WRITE} cmd_kind_t;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} rd_state_t;
  typedef enum logic [1:0] {WR_IDLE, WR_COLLECT} wr_state_t;
  typedef enum logic [1:0] {C_IDLE, C_MRS, C_READ, C_WRITE} ctrl_state_t;

  function automatic logic [4:0] cas_cycles(input logic [3:0] code);
    logic [4:0] r;
    r = `CL_BASE + {2'h0, code[2:0]};
    if (code[3]) begin
      case (code[2:0])
        3'h0: r = 5'h12;
        3'h1: r = 5'h14;
        3'h2: r = 5'h16;
        3'h3: r = 5'h18;
        3'h4: r = 5'h17;
        3'h5: r = 5'h11;
        3'h6: r = 5'h13;
        default: r = 5'h15;
      endcase
    end
    return r;
  endfunction

  function automatic logic [5:0] read_cycles(input logic [3:0] clCode, input logic [1:0] alCode);
    logic [5:0] cl;
    logic [5:0] al;
    cl = {1'b0, cas_cycles(clCode)};
    al = 6'h00;
    if (alCode == `AL_CLM1) al = cl - 6'h01;
    if (alCode == `AL_CLM2) al = cl - 6'h02;
    return al + cl;
  endfunction

  function automatic logic is_chop(input logic [1:0] blMode, input logic bcBit);
    return (blMode == `BL_FIX4) || (blMode == `BL_OTF && !bcBit);
  endfunction

  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 63; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
endpackage

// file: common/mr0_link_if.sv
// Command, address and data pins between the memory controller and the memory device.
`timescale 1ns/100ps
interface mr0_link_if #(parameter int DW = 8);
  logic cmdValid;
  mr0_pkg::cmd_kind_t cmdKind;
  logic [2:0] bankSel;
  logic [17:0] addr;
  logic [7:0] crc;
  logic [DW-1:0] dqCtrl;
  logic dqCtrlOe_n;
  logic dm;
  logic [DW-1:0] dqDev;
  logic dqDevOe_n;
  logic dqsDev;
  logic dqsDevOe_n;
  modport device (input cmdValid, cmdKind, bankSel, addr, crc, dqCtrl, dqCtrlOe_n, dm,
                  output dqDev, dqDevOe_n, dqsDev, dqsDevOe_n);
  modport ctrl (output cmdValid, cmdKind, bankSel, addr, crc, dqCtrl, dqCtrlOe_n, dm,
                input dqDev, dqDevOe_n, dqsDev, dqsDevOe_n);
endinterface

// file: core/burst_order.sv
// Beat index of one burst slot for sequential or interleaved ordering.
`timescale 1ns/100ps
module burst_order (
  input wire logic [2:0] start,
  input wire logic [2:0] count,
  input wire logic interleaved,
  output logic [2:0] index
);
  always_comb begin
    if (interleaved) begin
      index = start ^ count;
    end else begin
      index = {start[2] ^ count[2], start[1:0] + count[1:0]};
    end
  end
endmodule

// file: core/mr0_device.sv
// Memory device end: mode register zero decode, burst ordering, read latency and write commit.
// What this block does
// - Order beats by burst type, length, start.
// - Fixed chop-four, fixed eight, or per-command select.
// - First beat is start column; wrap or XOR.
// - Chop-four read: drivers off beats four-seven.
// - Writes ignore low column bits; fixed order.
// - Fixed chop-four write commits two clocks early.
// - Per-command chop-four write commits at eight-beat time.
// - Column latency is whole clock cycles.
// - First read data after added plus column latency.
// - Controller keeps test-mode bit at zero.
// - Controller programs recovery code at least minimum.
// - Mask and CRC enabled: bad CRC blocks write.
// - Controller programs read-to-precharge at least minimum.
// - Delay-lock reset bit clears itself.
// - Controller waits lock interval after delay-lock reset.
// - Mode commands with select 111 are ignored.
// - Controller zeroes unused mode address bit 17.
// - Gear-down forbidden latency codes: controller passes them through unchecked.
`timescale 1ns/100ps
`include "mr0_map.svh"
module mr0_device #(
  parameter int DW = 8,
  parameter int COLW = 6
) (
  input wire logic mclk,
  input wire logic reset,
  mr0_link_if.device link,
  output logic [1:0] burstMode,
  output logic interleavedOrder,
  output logic [5:0] totalReadLatency,
  output logic [2:0] recoveryCode,
  output logic testModeActive,
  output logic dllResetPulse,
  output logic internalWrite,
  output logic writeBlocked
);
  typedef struct packed {
    logic [1:0] blMode;
    logic interleaved;
    logic [3:0] clCode;
    logic testMode;
    logic dllReset;
    logic [2:0] wrCode;
    logic [1:0] alCode;
    logic crcEn;
    logic dmEn;
    mr0_pkg::rd_state_t rdState;
    logic [5:0] rdWait;
    logic [3:0] rdBeat;
    logic rdChop;
    logic [COLW-1:0] rdCol;
    logic [DW-1:0] dqOut;
    logic dqOe_n;
    logic dqs;
    logic dqsOe_n;
    mr0_pkg::wr_state_t wrState;
    logic [3:0] wrCnt;
    logic wrChop;
    logic wrEarly;
    logic [COLW-1:0] wrCol;
    logic [8*DW-1:0] wrBuf;
    logic [7:0] wrMask;
    logic [7:0] wrCrc;
    logic internalWrite;
    logic writeBlocked;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;
  logic [DW-1:0] mem [0:(1<<COLW)-1];
  logic [2:0] slot;
  logic [2:0] beatIdx;
  logic isMrs;
  logic isRead;
  logic isWrite;
  logic driveBeat;
  logic crcOk;
  logic [63:0] crcData;
  logic [3:0] commitAt;

  assign isMrs = link.cmdValid && link.cmdKind == mr0_pkg::CMD_MRS;
  assign isRead = link.cmdValid && link.cmdKind == mr0_pkg::CMD_READ;
  assign isWrite = link.cmdValid && link.cmdKind == mr0_pkg::CMD_WRITE;
  assign slot = (s.rdState == mr0_pkg::RD_WAIT) ? 3'h0 : s.rdBeat[2:0];
  assign driveBeat = (s.rdState == mr0_pkg::RD_WAIT && s.rdWait == 6'h00) ||
                     (s.rdState == mr0_pkg::RD_BURST && s.rdBeat < `BURST_SLOT);

  burst_order order (
    .start(s.rdCol[2:0]),
    .count(slot),
    .interleaved(s.interleaved),
    .index(beatIdx)
  );

  // Beats past a chop-four burst are zeroed so both ends compute the checksum over the same bits.
  always_comb begin
    crcData = 64'h0;
    crcData[8*DW-1:0] = s.wrBuf;
    if (s.wrChop) crcData[63:32] = 32'h0;
  end

  assign crcOk = mr0_pkg::crc8(crcData) == s.wrCrc;
  assign commitAt = s.wrEarly ? (`BURST_SLOT - `WR_PULL_IN) : `BURST_SLOT;

  always_comb begin
    next_s = s;
    next_s.dllReset = 1'b0;
    next_s.internalWrite = 1'b0;
    next_s.writeBlocked = 1'b0;
    // Each register changes only on its own select code; the control-word code matches no item.
    if (isMrs) begin
      case (link.bankSel)
        `MRSEL_MR0: begin
          next_s.blMode = link.addr[`BIT_BL+1:`BIT_BL];
          next_s.interleaved = link.addr[`BIT_BT];
          next_s.clCode = {link.addr[`BIT_CL_HI+2:`BIT_CL_HI], link.addr[`BIT_CL_LO]};
          next_s.testMode = link.addr[`BIT_TM];
          next_s.dllReset = link.addr[`BIT_DLLRST];
          next_s.wrCode = link.addr[`BIT_WR+2:`BIT_WR];
        end
        `MRSEL_MR1: next_s.alCode = link.addr[`BIT_AL+1:`BIT_AL];
        `MRSEL_MR2: next_s.crcEn = link.addr[`BIT_CRC];
        `MRSEL_MR5: next_s.dmEn = link.addr[`BIT_DM];
        default: ;
      endcase
    end

    next_s.dqOe_n = 1'b1;
    next_s.dqsOe_n = 1'b1;
    next_s.dqOut = '0;
    next_s.dqs = 1'b0;
    if (driveBeat) begin
      next_s.dqOe_n = s.rdChop && slot[2];
      next_s.dqsOe_n = s.rdChop && slot[2];
      next_s.dqOut = mem[{s.rdCol[COLW-1:3], beatIdx}];
      next_s.dqs = !slot[0];
    end
    unique case (s.rdState)
      mr0_pkg::RD_IDLE: begin
        if (isRead) begin
          next_s.rdState = mr0_pkg::RD_WAIT;
          // Latency is counted in whole clocks from the command edge.
          next_s.rdWait = mr0_pkg::read_cycles(s.clCode, s.alCode) - 6'h01;
          next_s.rdCol = link.addr[COLW-1:0];
          next_s.rdChop = mr0_pkg::is_chop(s.blMode, link.addr[`BIT_BC]);
        end
      end
      mr0_pkg::RD_WAIT: begin
        next_s.rdWait = s.rdWait - 6'h01;
        if (s.rdWait == 6'h00) begin
          next_s.rdState = mr0_pkg::RD_BURST;
          next_s.rdBeat = 4'h1;
        end
      end
      mr0_pkg::RD_BURST: begin
        next_s.rdBeat = s.rdBeat + 4'h1;
        if (s.rdBeat == `BURST_SLOT) next_s.rdState = mr0_pkg::RD_IDLE;
      end
    endcase

    unique case (s.wrState)
      mr0_pkg::WR_IDLE: begin
        if (isWrite) begin
          next_s.wrState = mr0_pkg::WR_COLLECT;
          next_s.wrCnt = 4'h0;
          next_s.wrChop = mr0_pkg::is_chop(s.blMode, link.addr[`BIT_BC]);
          next_s.wrEarly = s.blMode == `BL_FIX4;
          next_s.wrCol = link.addr[COLW-1:0];
          next_s.wrBuf = '0;
          next_s.wrMask = 8'h00;
          next_s.wrCrc = link.crc;
        end
      end
      mr0_pkg::WR_COLLECT: begin
        if (s.wrCnt < `BURST_SLOT) begin
          next_s.wrBuf[s.wrCnt[2:0]*DW +: DW] = link.dqCtrl;
          next_s.wrMask[s.wrCnt[2:0]] = link.dm;
          next_s.wrCnt = s.wrCnt + 4'h1;
        end
        if (s.wrCnt == commitAt) begin
          next_s.wrState = mr0_pkg::WR_IDLE;
          // A checksum mismatch only blocks while both mask and checksum are enabled.
          next_s.writeBlocked = s.dmEn && s.crcEn && !crcOk;
          next_s.internalWrite = !(s.dmEn && s.crcEn && !crcOk);
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.dqOe_n <= 1'b1;
      s.dqsOe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // The array is written one clock after the commit pulse, from the held burst buffer.
  always_ff @(posedge mclk) begin
    if (s.internalWrite) begin
      for (int k = 0; k < 8; k++) begin
        if (!(s.wrChop && k >= 4) && !(s.dmEn && s.wrMask[k])) begin
          if (s.wrChop) begin
            mem[{s.wrCol[COLW-1:3], s.wrCol[2], 2'(k)}] <= s.wrBuf[k*DW +: DW];
          end else begin
            mem[{s.wrCol[COLW-1:3], 3'(k)}] <= s.wrBuf[k*DW +: DW];
          end
        end
      end
    end
  end

  assign link.dqDev = s.dqOut;
  assign link.dqDevOe_n = s.dqOe_n;
  assign link.dqsDev = s.dqs;
  assign link.dqsDevOe_n = s.dqsOe_n;
  assign burstMode = s.blMode;
  assign interleavedOrder = s.interleaved;
  assign totalReadLatency = mr0_pkg::read_cycles(s.clCode, s.alCode);
  assign recoveryCode = s.wrCode;
  assign testModeActive = s.testMode;
  assign dllResetPulse = s.dllReset;
  assign internalWrite = s.internalWrite;
  assign writeBlocked = s.writeBlocked;
endmodule

// file: core/mr0_controller.sv
// Memory controller end: Avalon-MM command registers driving mode, read and write commands.
`timescale 1ns/100ps
`include "mr0_map.svh"
module mr0_controller #(
  parameter int DW = 8,
  parameter int LOCK_CYCLES = `LOCK_WAIT_CYCLES,
  parameter logic [2:0] RECOVERY_CODE_MIN = 3'h0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  mr0_link_if.ctrl link
);
  localparam int LW = $clog2(LOCK_CYCLES + 1);

  typedef struct packed {
    mr0_pkg::ctrl_state_t cstate;
    logic cmdValid;
    mr0_pkg::cmd_kind_t cmdKind;
    logic [2:0] bankSel;
    logic [17:0] addr;
    logic [7:0] crc;
    logic [63:0] wdata;
    logic [7:0] mask;
    logic [63:0] rdata;
    logic [6:0] cnt;
    logic [LW-1:0] lockCnt;
    logic [1:0] blMode;
    logic [3:0] clCode;
    logic [1:0] alCode;
    logic [DW-1:0] dq;
    logic dqOe_n;
    logic dm;
    logic [31:0] readdata;
    logic rdAck;
  } ctrl_st_t;

  ctrl_st_t s;
  ctrl_st_t next_s;
  logic wrCmd;
  logic busy;
  logic taken;
  logic [6:0] rl;
  logic [6:0] rdSlot;
  mr0_pkg::cmd_kind_t kind;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    return r;
  endfunction

  assign kind = mr0_pkg::cmd_kind_t'(writedata[`CMD_KIND+1:`CMD_KIND]);
  assign busy = s.cstate != mr0_pkg::C_IDLE;
  assign wrCmd = write && address == `REG_CMD;
  // Reads are held off while the delay-lock is settling.
  assign waitrequest = (read && !s.rdAck) ||
                       (wrCmd && (busy || (kind == mr0_pkg::CMD_READ && s.lockCnt != '0)));
  assign taken = write && !waitrequest;
  assign rl = {1'b0, mr0_pkg::read_cycles(s.clCode, s.alCode)};
  assign rdSlot = s.cnt - rl - 7'h01;

  always_comb begin
    next_s = s;
    next_s.cmdValid = 1'b0;
    next_s.rdAck = 1'b0;
    if (s.lockCnt != '0) next_s.lockCnt = s.lockCnt - 1'b1;
    if (read && !s.rdAck) begin
      next_s.rdAck = 1'b1;
      case (address)
        `REG_CMD: next_s.readdata = {8'h00, 1'b0, s.cmdKind, s.bankSel, s.addr};
        `REG_WDATA0: next_s.readdata = s.wdata[31:0];
        `REG_WDATA1: next_s.readdata = s.wdata[63:32];
        `REG_MASK: next_s.readdata = {24'h0, s.mask};
        `REG_STATUS: next_s.readdata = {30'h0, s.lockCnt != '0, busy};
        `REG_RDATA0: next_s.readdata = s.rdata[31:0];
        `REG_RDATA1: next_s.readdata = s.rdata[63:32];
        default: next_s.readdata = 32'h0;
      endcase
    end
    if (taken && address == `REG_WDATA0) next_s.wdata[31:0] = merge(s.wdata[31:0], writedata, byteenable);
    if (taken && address == `REG_WDATA1) next_s.wdata[63:32] = merge(s.wdata[63:32], writedata, byteenable);
    if (taken && address == `REG_MASK && byteenable[0]) next_s.mask = writedata[7:0];
    if (taken && wrCmd && kind != mr0_pkg::CMD_NOP) begin
      next_s.cmdValid = 1'b1;
      next_s.cmdKind = kind;
      next_s.bankSel = writedata[`CMD_SEL+2:`CMD_SEL];
      next_s.addr = writedata[17:0];
      next_s.cnt = 7'h00;
      next_s.cstate = mr0_pkg::C_MRS;
      if (kind == mr0_pkg::CMD_MRS) begin
        next_s.addr[`BIT_UNUSED] = 1'b0;
        if (writedata[`CMD_SEL+2:`CMD_SEL] == `MRSEL_MR0) begin
          next_s.addr[`BIT_TM] = 1'b0;
          if (writedata[`BIT_WR+2:`BIT_WR] < RECOVERY_CODE_MIN) begin
            next_s.addr[`BIT_WR+2:`BIT_WR] = RECOVERY_CODE_MIN;
          end
          next_s.blMode = writedata[`BIT_BL+1:`BIT_BL];
          next_s.clCode = {writedata[`BIT_CL_HI+2:`BIT_CL_HI], writedata[`BIT_CL_LO]};
          if (writedata[`BIT_DLLRST]) next_s.lockCnt = LW'(LOCK_CYCLES);
        end
        if (writedata[`CMD_SEL+2:`CMD_SEL] == `MRSEL_MR1) next_s.alCode = writedata[`BIT_AL+1:`BIT_AL];
      end else if (kind == mr0_pkg::CMD_READ) begin
        next_s.cstate = mr0_pkg::C_READ;
        next_s.rdata = 64'h0;
      end else begin
        next_s.cstate = mr0_pkg::C_WRITE;
        // The checksum covers the first four beats only when the burst is chopped.
        if (mr0_pkg::is_chop(s.blMode, writedata[`BIT_BC])) begin
          next_s.crc = mr0_pkg::crc8({32'h0, s.wdata[31:0]}) ^ {7'h00, writedata[`CMD_BADCRC]};
        end else begin
          next_s.crc = mr0_pkg::crc8(s.wdata) ^ {7'h00, writedata[`CMD_BADCRC]};
        end
      end
    end
    next_s.dqOe_n = 1'b1;
    next_s.dq = '0;
    next_s.dm = 1'b0;
    unique case (s.cstate)
      mr0_pkg::C_IDLE: ;
      mr0_pkg::C_MRS: next_s.cstate = mr0_pkg::C_IDLE;
      mr0_pkg::C_WRITE: begin
        next_s.cnt = s.cnt + 7'h01;
        if (s.cnt < 7'h08) begin
          next_s.dq = s.wdata[s.cnt[2:0]*DW +: DW];
          next_s.dm = s.mask[s.cnt[2:0]];
          next_s.dqOe_n = 1'b0;
        end
        if (s.cnt == 7'(`WR_DONE)) next_s.cstate = mr0_pkg::C_IDLE;
      end
      mr0_pkg::C_READ: begin
        next_s.cnt = s.cnt + 7'h01;
        if (s.cnt > rl && rdSlot < 7'h08 && !link.dqDevOe_n) next_s.rdata[rdSlot[2:0]*DW +: DW] = link.dqDev;
        if (s.cnt == rl + 7'h09) next_s.cstate = mr0_pkg::C_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.dqOe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign readdata = s.readdata;
  assign link.cmdValid = s.cmdValid;
  assign link.cmdKind = s.cmdKind;
  assign link.bankSel = s.bankSel;
  assign link.addr = s.addr;
  assign link.crc = s.crc;
  assign link.dqCtrl = s.dq;
  assign link.dqCtrlOe_n = s.dqOe_n;
  assign link.dm = s.dm;
endmodule

// file: tb/mr0_link_assertions.sv
// Concurrent checks on the mode register zero link and the device's decoded outputs.
`timescale 1ns/100ps
module mr0_link_assertions #(
  parameter int LOCK_CYCLES = 1024,
  parameter logic [2:0] RECOVERY_CODE_MIN = 3'h0
) (
  input logic mclk,
  input logic reset,
  input logic cmdValid,
  input mr0_pkg::cmd_kind_t cmdKind,
  input logic [2:0] bankSel,
  input logic [17:0] addr,
  input logic dqDevOe_n,
  input logic dqsDevOe_n,
  input logic [1:0] burstMode,
  input logic interleavedOrder,
  input logic [5:0] totalReadLatency,
  input logic [2:0] recoveryCode,
  input logic dllResetPulse,
  input logic internalWrite,
  input logic writeBlocked
);
  logic [6:0] rcnt;
  logic [5:0] rl;
  logic rchop;
  logic [15:0] lockCnt;
  logic rdCmd;
  logic wrCmd;
  logic mrsCmd;
  logic commit;
  assign rdCmd = cmdValid && cmdKind == mr0_pkg::CMD_READ;
  assign wrCmd = cmdValid && cmdKind == mr0_pkg::CMD_WRITE;
  assign mrsCmd = cmdValid && cmdKind == mr0_pkg::CMD_MRS;
  assign commit = internalWrite || writeBlocked;
  // The window counter saturates so a long idle stretch never wraps back into a beat slot.
  always_ff @(posedge mclk) begin
    if (reset) begin
      rcnt <= 7'h00;
      lockCnt <= 16'h0000;
    end else begin
      if (rdCmd) begin
        rcnt <= 7'h01;
        rl <= totalReadLatency;
        rchop <= (burstMode == 2'h2) || (burstMode == 2'h1 && !addr[12]);
      end else if (rcnt != 7'h00 && rcnt != 7'h7f) begin
        rcnt <= rcnt + 7'h01;
      end
      if (dllResetPulse) begin
        lockCnt <= 16'(LOCK_CYCLES - 2);
      end else if (lockCnt != 16'h0000) begin
        lockCnt <= lockCnt - 16'h0001;
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  rd_window_a: assert property (rcnt >= {1'b0, rl} && rcnt <= {1'b0, rl} + 7'h08 |->
    dqDevOe_n == (rcnt == {1'b0, rl} || (rchop && rcnt > {1'b0, rl} + 7'h04))) else $error("read beat window wrong");
  strobe_oe_a: assert property (dqsDevOe_n == dqDevOe_n)
    else $error("strobe enable differs from data enable");
  wr8_commit_a: assert property (wrCmd && burstMode != 2'h2 |-> ##8 !commit ##2 commit)
    else $error("eight-beat write commit time wrong");
  wr4_commit_a: assert property (wrCmd && burstMode == 2'h2 |-> ##8 commit)
    else $error("fixed chop write commit time wrong");
  dll_pulse_a: assert property (mrsCmd && bankSel == 3'h0 && addr[8] |=> dllResetPulse ##1 !dllResetPulse)
    else $error("delay-lock reset bit did not self clear");
  lock_wait_a: assert property (rdCmd |-> lockCnt == 16'h0000)
    else $error("read issued inside lock interval");
  fields_hold_a: assert property (!mrsCmd |=> $stable({burstMode, interleavedOrder, totalReadLatency, recoveryCode}))
    else $error("mode field changed without a mode command");
  rcw_ignore_a: assert property (mrsCmd && bankSel == 3'h7 |=> $stable({burstMode, totalReadLatency}))
    else $error("control word select not ignored");
  test_bit_a: assert property (mrsCmd && bankSel == 3'h0 |-> !addr[7])
    else $error("test mode bit sent high");
  a17_zero_a: assert property (mrsCmd |-> !addr[17])
    else $error("unused mode address bit sent high");
  recovery_min_a: assert property (mrsCmd && bankSel == 3'h0 |-> addr[11:9] >= RECOVERY_CODE_MIN)
    else $error("recovery code below minimum");
  cover property (rchop && rcnt == {1'b0, rl} + 7'h05);
  cover property (rdCmd && burstMode == 2'h1);
  cover property (writeBlocked);
  cover property (dllResetPulse);
endmodule

// file: tb/dram_mode_register_zero_logic_tb.sv
// Bench joining controller and device over the link, driven through the Avalon command registers.
`timescale 1ns/100ps
module dram_mode_register_zero_logic_tb;
  localparam int LOCK = 16;
  typedef struct packed {logic [2:0] sel; logic [17:0] a; logic [1:0] bm; logic il; logic [5:0] rl; logic [2:0] rec;} mrs_row_t;
  typedef struct packed {logic [17:0] mode; logic [17:0] rd; logic chop; logic [31:0] r0; logic [31:0] r1;} rd_row_t;
  logic mclk;
  logic reset;
  logic read;
  logic write;
  logic [4:0] address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic [31:0] q;
  logic [3:0] byteenable;
  logic waitrequest;
  logic [1:0] burstMode;
  logic interleavedOrder;
  logic [5:0] totalReadLatency;
  logic [2:0] recoveryCode;
  logic testModeActive;
  logic dllResetPulse;
  logic internalWrite;
  logic writeBlocked;
  logic [17:0] lastMrs;
  int failCount = 0;
  int checkCount = 0;
  // Recovery minimum is two, so every plain code below two comes back raised.
  mrs_row_t mrsRows [0:9] = '{{3'h0, 18'h00000, 2'h0, 1'b0, 6'h09, 3'h2}, {3'h0, 18'h0021d, 2'h1, 1'b1, 6'h0c, 3'h2},
    {3'h0, 18'h00a42, 2'h2, 1'b0, 6'h12, 3'h5}, {3'h1, 18'h00008, 2'h2, 1'b0, 6'h23, 3'h5},
    {3'h7, 18'h00001, 2'h2, 1'b0, 6'h23, 3'h5}, {3'h3, 18'h00000, 2'h2, 1'b0, 6'h23, 3'h5},
    {3'h1, 18'h00010, 2'h2, 1'b0, 6'h22, 3'h5}, {3'h0, 18'h00674, 2'h0, 1'b0, 6'h28, 3'h3},
    {3'h1, 18'h00000, 2'h0, 1'b0, 6'h15, 3'h3}, {3'h0, 18'h20ec2, 2'h2, 1'b0, 6'h12, 3'h7}};
  rd_row_t rdRows [0:5] = '{{18'h00000, 18'h00005, 1'b0, 32'h14171615, 32'h10131211},
    {18'h00008, 18'h00006, 1'b0, 32'h15141716, 32'h11101312}, {18'h00002, 18'h00003, 1'b1, 32'h12111013, 32'h0},
    {18'h0000a, 18'h00005, 1'b1, 32'h16171415, 32'h0}, {18'h00001, 18'h01002, 1'b0, 32'h11101312, 32'h15141716},
    {18'h00009, 18'h00007, 1'b1, 32'h14151617, 32'h0}};
  mr0_link_if link ();
  mr0_device mr0_device_inst (.mclk(mclk), .reset(reset), .link(link), .burstMode(burstMode),
    .interleavedOrder(interleavedOrder), .totalReadLatency(totalReadLatency), .recoveryCode(recoveryCode),
    .testModeActive(testModeActive), .dllResetPulse(dllResetPulse), .internalWrite(internalWrite),
    .writeBlocked(writeBlocked));
  mr0_controller #(.LOCK_CYCLES(LOCK), .RECOVERY_CODE_MIN(3'h2)) mr0_controller_inst (.mclk(mclk),
    .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .link(link));
  mr0_link_assertions #(.LOCK_CYCLES(LOCK), .RECOVERY_CODE_MIN(3'h2)) mr0_link_assertions_inst (.mclk(mclk),
    .reset(reset), .cmdValid(link.cmdValid), .cmdKind(link.cmdKind), .bankSel(link.bankSel), .addr(link.addr),
    .dqDevOe_n(link.dqDevOe_n), .dqsDevOe_n(link.dqsDevOe_n), .burstMode(burstMode),
    .interleavedOrder(interleavedOrder),
    .totalReadLatency(totalReadLatency), .recoveryCode(recoveryCode), .dllResetPulse(dllResetPulse),
    .internalWrite(internalWrite), .writeBlocked(writeBlocked));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (link.cmdValid === 1'b1 && link.cmdKind === mr0_pkg::CMD_MRS) lastMrs <= link.addr;
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One idle cycle separates requests, so no strobe is lowered and raised in one time step.
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic idle();
    for (int i = 0; i < 200; i++) begin
      av(1'b0, 5'h10, 32'h0);
      if (q[0] === 1'b0) break;
      if (i == 199) failCount++;
    end
  endtask
  task automatic cmd(input logic [1:0] kind, input logic [2:0] sel, input logic [17:0] a, input logic bad);
    av(1'b1, 5'h00, {8'h00, bad, kind, sel, a});
    idle();
  endtask
  task automatic wr(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] m, input logic [17:0] a,
                    input logic bad);
    av(1'b1, 5'h04, w0);
    av(1'b1, 5'h08, w1);
    av(1'b1, 5'h0c, m);
    cmd(2'h3, 3'h0, a, bad);
  endtask
  task automatic rdchk(input logic [17:0] ra, input logic [31:0] r0, input logic [31:0] r1, input logic chop);
    cmd(2'h2, 3'h0, ra, 1'b0);
    av(1'b0, 5'h14, 32'h0);
    check("rdata0", q, r0);
    if (!chop) begin
      av(1'b0, 5'h18, 32'h0);
      check("rdata1", q, r1);
    end
  endtask
  task automatic devchk(input logic [1:0] bm, input logic il, input logic [5:0] rl, input logic [2:0] rec);
    check("burstMode", {30'h0, burstMode}, {30'h0, bm});
    check("interleavedOrder", {31'h0, interleavedOrder}, {31'h0, il});
    check("totalReadLatency", {26'h0, totalReadLatency}, {26'h0, rl});
    check("recoveryCode", {29'h0, recoveryCode}, {29'h0, rec});
  endtask
  initial begin
    #200000;
    failCount++;
    closeOut();
  end
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    reset = 1'b1;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    devchk(2'h0, 1'b0, 6'h09, 3'h0);
    av(1'b0, 5'h1c, 32'h0);
    check("unmapped", q, 32'h0);
    byteenable <= 4'h2;
    av(1'b1, 5'h04, 32'hffffa5ff);
    byteenable <= 4'hf;
    av(1'b0, 5'h04, 32'h0);
    check("byteMerge", q, 32'h0000a500);
    $display("reset test done");
    foreach (mrsRows[i]) begin
      cmd(2'h1, mrsRows[i].sel, mrsRows[i].a, 1'b0);
      devchk(mrsRows[i].bm, mrsRows[i].il, mrsRows[i].rl, mrsRows[i].rec);
    end
    check("mrsAddr", {14'h0, lastMrs}, 32'h00e42);
    check("testMode", {31'h0, testModeActive}, 32'h0);
    $display("mode table done");
    cmd(2'h1, 3'h0, 18'h00000, 1'b0);
    wr(32'h13121110, 32'h17161514, 32'h0, 18'h00007, 1'b0);
    foreach (rdRows[i]) begin
      cmd(2'h1, 3'h0, rdRows[i].mode, 1'b0);
      rdchk(rdRows[i].rd, rdRows[i].r0, rdRows[i].r1, rdRows[i].chop);
    end
    $display("burst table done");
    cmd(2'h1, 3'h0, 18'h00002, 1'b0);
    wr(32'h23222120, 32'h0, 32'h0, 18'h00005, 1'b0);
    cmd(2'h1, 3'h0, 18'h00000, 1'b0);
    rdchk(18'h00000, 32'h13121110, 32'h23222120, 1'b0);
    cmd(2'h1, 3'h5, 18'h00400, 1'b0);
    wr(32'h33323130, 32'h37363534, 32'h1, 18'h00000, 1'b0);
    rdchk(18'h00000, 32'h33323110, 32'h37363534, 1'b0);
    cmd(2'h1, 3'h2, 18'h01000, 1'b0);
    wr(32'h43424140, 32'h47464544, 32'h0, 18'h00000, 1'b1);
    rdchk(18'h00000, 32'h33323110, 32'h37363534, 1'b0);
    cmd(2'h1, 3'h0, 18'h00001, 1'b0);
    wr(32'h43424140, 32'h0, 32'h0, 18'h00004, 1'b0);
    cmd(2'h1, 3'h0, 18'h00000, 1'b0);
    rdchk(18'h00000, 32'h33323110, 32'h43424140, 1'b0);
    $display("write paths done");
    cmd(2'h1, 3'h0, 18'h00100, 1'b0);
    check("lockWait", {31'h0, q[1]}, 32'h1);
    rdchk(18'h00000, 32'h33323110, 32'h43424140, 1'b0);
    $display("lock wait done");
    cmd(2'h1, 3'h0, 18'h0000a, 1'b0);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    devchk(2'h0, 1'b0, 6'h09, 3'h0);
    $display("mid reset done");
    closeOut();
  end
endmodule
